/* design/sppm_pin_mux.sv */
// Pin multiplexer for serial-flash master, PWM, keypad and panel-clock pins.
// Assumes one core clock, pad cells outside, and that the clock runs during reset
// so that the reset-time pull-up on the second select follows the test-mode pins.
`timescale 1ns/100ps

// What this block does
// RULE1 - Chip selects become port C3/C4, default input
// RULE2 - Clock, MOSI, MISO become port C0-C2, default input
// RULE3 - Pull second select high in reset, unless floating
// RULE4 - Single mode: MOSI drives, MISO samples
// RULE5 - Dual mode: both lines bidirectional flash data
// RULE6 - Strap on first PWM pin enables initial display
// RULE7 - Pull first PWM pin down only during reset
// RULE8 - PWM off: first pin is C7 or core clock
// RULE9 - Clock test low: second PWM pin selectable output
// RULE10 - Clock test high: second PWM pin is clock input
// RULE11 - Sense lines pulled-up inputs; line zero I2C clock
// RULE12 - Strobe lines open-drain; line zero I2C data
// RULE13 - Lines one to four owned by one function
// RULE14 - Panel scan clock comes from scan PLL; from second PWM pin when clock test high
// RULE15 - Test code 01 floats all flash pins
// RULE16 - One driver per pin; pin always readable back
module sppm_pin_mux #(
	parameter int SYNC_STAGES = sppm_pkg::SYNC_STAGES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [sppm_pkg::SPI_PADS-1:0] spiPadIn,
	output logic [sppm_pkg::SPI_PADS-1:0] spiPadOut_r,
	output logic [sppm_pkg::SPI_PADS-1:0] spiPadOe_r,
	output logic flashSelectOnePullUp_r,
	input wire logic pwm0PadIn,
	output logic pwm0PadOut_r,
	output logic pwm0PadOe_r,
	output logic pwm0PullDown_r,
	input wire logic pwm1PadIn,
	output logic pwm1PadOut_r,
	output logic pwm1PadOe_r,
	input wire logic [sppm_pkg::KEY_LINES-1:0] keySensePadIn,
	output logic [sppm_pkg::KEY_LINES-1:0] keySensePadOut_r,
	output logic [sppm_pkg::KEY_LINES-1:0] keySensePadOe_r,
	output logic [sppm_pkg::KEY_LINES-1:0] keySensePullUp_r,
	input wire logic [sppm_pkg::KEY_LINES-1:0] keyStrobePadIn,
	output logic [sppm_pkg::KEY_LINES-1:0] keyStrobePadOut_r,
	output logic [sppm_pkg::KEY_LINES-1:0] keyStrobePadOe_r,
	output logic panelScanClkOut_r,
	input wire logic clockTestPin,
	input wire logic [1:0] chipTestPin,
	input wire logic spiMasterEn,
	input wire logic dualLineMode,
	input wire sppm_pkg::sppm_spi_fn_t spiFn,
	output logic spiMasterInData_r,
	output logic [1:0] dualDataIn_r,
	input wire logic [sppm_pkg::GPIOC_W-1:0] gpioCOut,
	input wire logic [sppm_pkg::GPIOC_W-1:0] gpioCOe,
	output logic [sppm_pkg::GPIOC_W-1:0] gpioCIn_r,
	input wire logic pwmEn,
	input wire logic pwm0Value,
	input wire logic pwm0CoreClkSel,
	input wire logic coreClkTap,
	input wire sppm_pkg::sppm_pwm1_sel_t pwm1Sel,
	input wire logic pwm1Value,
	input wire logic oscClkTap,
	input wire logic scanBandwidthErr,
	input wire logic memRangeErr,
	output logic initDisplayEn_r,
	output logic clockTestMode_r,
	output logic extPanelScanClk_r,
	input wire logic i2cMasterEn,
	input wire logic i2cSclOut,
	input wire logic i2cSdaOut,
	output logic i2cSclIn_r,
	output logic i2cSdaIn_r,
	input wire logic [sppm_pkg::KEY_LINES-1:0] keyStrobeOut,
	output logic [sppm_pkg::KEY_LINES-1:0] keySenseIn_r,
	input wire sppm_pkg::sppm_owner_t [sppm_pkg::KEY_LINES-1:1] lineOwner,
	input wire logic [sppm_pkg::GPIOD_W-1:0] panelDataOut,
	input wire logic [sppm_pkg::GPIOD_W-1:0] gpioDOut,
	input wire logic [sppm_pkg::GPIOD_W-1:0] gpioDOe,
	output logic [sppm_pkg::GPIOD_W-1:0] gpioDIn_r,
	input wire logic scanPllClkTap
);

	if (SYNC_STAGES < 3) begin : g_bad_sync
		$error("SYNC_STAGES must be at least 3");
	end
	logic [sppm_pkg::IN_W-1:0] rawIn;
	logic [sppm_pkg::IN_W-1:0] pinAgree;
	logic [sppm_pkg::IN_W-1:0] pinLate;
	logic [sppm_pkg::IN_W-1:0] pinFilt_r;
	logic resetActive_r;
	logic floatSpi;
	logic [sppm_pkg::SPI_PADS-1:0] spiOut_nxt;
	logic [sppm_pkg::SPI_PADS-1:0] spiOe_nxt;
	logic [sppm_pkg::KEY_LINES-1:0] senseOut_nxt;
	logic [sppm_pkg::KEY_LINES-1:0] senseOe_nxt;
	logic [sppm_pkg::KEY_LINES-1:0] sensePull_nxt;
	logic [sppm_pkg::KEY_LINES-1:0] strobeOut_nxt;
	logic [sppm_pkg::KEY_LINES-1:0] strobeOe_nxt;
	logic [sppm_pkg::KEY_LINES-1:0] senseFilt;
	logic [sppm_pkg::KEY_LINES-1:0] strobeFilt;
	logic [sppm_pkg::SPI_PADS-1:0] spiFilt;
	logic [1:0] chipTest;
	logic clockTest;
	assign rawIn = {chipTestPin, clockTestPin, keyStrobePadIn, keySensePadIn,
		pwm1PadIn, pwm0PadIn, spiPadIn};
	// Synchronisers carry no reset so that test-mode and strap pins are seen in reset
	for (genvar i = 0; i < sppm_pkg::IN_W; i++) begin : g_sync
		logic [SYNC_STAGES-1:0] stage;
		always_ff @(posedge clock) begin
			stage <= {stage[SYNC_STAGES-2:0], rawIn[i]};
		end
		always_ff @(posedge clock) begin
			if (stage[SYNC_STAGES-2] == stage[SYNC_STAGES-1]) begin
				pinFilt_r[i] <= stage[SYNC_STAGES-1];
			end
		end
		assign pinAgree[i] = stage[SYNC_STAGES-2] == stage[SYNC_STAGES-1];
		assign pinLate[i] = stage[SYNC_STAGES-1];
	end
	assign chipTest = pinFilt_r[sppm_pkg::IN_CHIPTEST +: 2];
	assign clockTest = pinFilt_r[sppm_pkg::IN_CLKTEST];
	assign floatSpi = chipTest == sppm_pkg::TEST_FLOAT_SPI;
	assign spiFilt = pinFilt_r[sppm_pkg::IN_SPI +: sppm_pkg::SPI_PADS];
	assign senseFilt = pinFilt_r[sppm_pkg::IN_SENSE +: sppm_pkg::KEY_LINES];
	assign strobeFilt = pinFilt_r[sppm_pkg::IN_STROBE +: sppm_pkg::KEY_LINES];
	// Strap is taken on the first agreed sample after release, while the pull-down still held
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			resetActive_r <= 1'h1;
			pwm0PullDown_r <= sppm_pkg::RST_PWM0_PULLDOWN;
			initDisplayEn_r <= sppm_pkg::RST_INIT_DISPLAY;
		end else if (resetActive_r && pinAgree[sppm_pkg::IN_PWM0]) begin
			resetActive_r <= 1'h0;
			pwm0PullDown_r <= 1'h0; // RULE7
			initDisplayEn_r <= pinLate[sppm_pkg::IN_PWM0]; // RULE6
		end
	end
	// Follows the test-mode pins during reset, hence no async reset here
	always_ff @(posedge clock) begin
		flashSelectOnePullUp_r <= resetActive_r && !floatSpi; // RULE3
	end
	always_comb begin
		spiOut_nxt = gpioCOut[sppm_pkg::SPI_PADS-1:0]; // RULE1 RULE2
		spiOe_nxt = gpioCOe[sppm_pkg::SPI_PADS-1:0]; // RULE1 RULE2
		if (floatSpi) begin
			spiOe_nxt = '0; // RULE15
		end else if (spiMasterEn) begin
			spiOut_nxt[sppm_pkg::PAD_SCLK] = spiFn.sclk;
			spiOut_nxt[sppm_pkg::PAD_CS0] = spiFn.cs0n;
			spiOut_nxt[sppm_pkg::PAD_CS1] = spiFn.cs1n;
			spiOe_nxt[sppm_pkg::PAD_SCLK] = 1'h1;
			spiOe_nxt[sppm_pkg::PAD_CS0] = 1'h1;
			spiOe_nxt[sppm_pkg::PAD_CS1] = 1'h1;
			if (dualLineMode) begin
				spiOut_nxt[sppm_pkg::PAD_MOSI] = spiFn.dualOut[0]; // RULE5
				spiOut_nxt[sppm_pkg::PAD_MISO] = spiFn.dualOut[1]; // RULE5
				spiOe_nxt[sppm_pkg::PAD_MOSI] = spiFn.dualOe[0]; // RULE5
				spiOe_nxt[sppm_pkg::PAD_MISO] = spiFn.dualOe[1]; // RULE5
			end else begin
				spiOut_nxt[sppm_pkg::PAD_MOSI] = spiFn.mosi; // RULE4
				spiOut_nxt[sppm_pkg::PAD_MISO] = 1'h0;
				spiOe_nxt[sppm_pkg::PAD_MOSI] = 1'h1; // RULE4
				spiOe_nxt[sppm_pkg::PAD_MISO] = 1'h0; // RULE4
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			spiPadOut_r <= {sppm_pkg::SPI_PADS{sppm_pkg::RST_OUT}};
			spiPadOe_r <= {sppm_pkg::SPI_PADS{sppm_pkg::RST_OE}};
		end else begin
			spiPadOut_r <= spiOut_nxt; // RULE16
			spiPadOe_r <= spiOe_nxt; // RULE16
		end
	end
	// Pin levels always return to port C, whichever function owns the pin
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			gpioCIn_r <= '0;
			spiMasterInData_r <= 1'h0;
			dualDataIn_r <= 2'h0;
		end else begin
			gpioCIn_r <= {pinFilt_r[sppm_pkg::IN_PWM0], 2'h0, spiFilt}; // RULE16
			spiMasterInData_r <= spiFilt[sppm_pkg::PAD_MISO]; // RULE4
			dualDataIn_r <= {spiFilt[sppm_pkg::PAD_MISO], spiFilt[sppm_pkg::PAD_MOSI]}; // RULE5
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pwm0PadOut_r <= sppm_pkg::RST_OUT;
			pwm0PadOe_r <= sppm_pkg::RST_OE;
		end else if (pwmEn) begin
			pwm0PadOut_r <= pwm0Value;
			pwm0PadOe_r <= 1'h1;
		end else if (pwm0CoreClkSel) begin
			pwm0PadOut_r <= coreClkTap; // RULE8
			pwm0PadOe_r <= 1'h1; // RULE8
		end else begin
			pwm0PadOut_r <= gpioCOut[sppm_pkg::GPIOC_PWM0]; // RULE8
			pwm0PadOe_r <= gpioCOe[sppm_pkg::GPIOC_PWM0]; // RULE8
		end
	end
	// Clock taps are resampled on the core clock; they serve as slow clocks only
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pwm1PadOut_r <= sppm_pkg::RST_OUT;
			pwm1PadOe_r <= sppm_pkg::RST_OE;
			panelScanClkOut_r <= sppm_pkg::RST_OUT;
			clockTestMode_r <= 1'h0;
			extPanelScanClk_r <= 1'h0;
		end else begin
			clockTestMode_r <= clockTest;
			extPanelScanClk_r <= pinFilt_r[sppm_pkg::IN_PWM1]; // RULE10
			panelScanClkOut_r <= clockTest ? pinFilt_r[sppm_pkg::IN_PWM1] : scanPllClkTap; // RULE14
			pwm1PadOe_r <= !clockTest; // RULE9 RULE10
			if (clockTest) begin
				pwm1PadOut_r <= 1'h0; // RULE10
			end else begin
				case (pwm1Sel)
					sppm_pkg::PWM1_PWM: pwm1PadOut_r <= pwm1Value; // RULE9
					sppm_pkg::PWM1_OSC: pwm1PadOut_r <= oscClkTap; // RULE9
					sppm_pkg::PWM1_ERR: pwm1PadOut_r <= scanBandwidthErr | memRangeErr; // RULE9
					default: pwm1PadOut_r <= 1'h0;
				endcase
			end
		end
	end
	// Open-drain lines never drive high: out stays low and only the enable moves
	for (genvar k = 0; k < sppm_pkg::KEY_LINES; k++) begin : g_key
		if (k == 0) begin : g_line0
			always_comb begin
				senseOut_nxt[k] = 1'h0;
				sensePull_nxt[k] = 1'h1; // RULE11
				senseOe_nxt[k] = i2cMasterEn && !i2cSclOut; // RULE11
				strobeOut_nxt[k] = 1'h0; // RULE12
				strobeOe_nxt[k] = i2cMasterEn ? !i2cSdaOut : !keyStrobeOut[k]; // RULE12
			end
		end else begin : g_shared
			always_comb begin
				senseOut_nxt[k] = 1'h0;
				senseOe_nxt[k] = 1'h0;
				sensePull_nxt[k] = 1'h0;
				strobeOut_nxt[k] = 1'h0;
				strobeOe_nxt[k] = 1'h0;
				case (lineOwner[k])
					sppm_pkg::OWN_KEY: begin
						sensePull_nxt[k] = 1'h1; // RULE11
						strobeOe_nxt[k] = !keyStrobeOut[k]; // RULE12 RULE13
					end
					sppm_pkg::OWN_PANEL: begin
						senseOut_nxt[k] = panelDataOut[k-1]; // RULE13
						senseOe_nxt[k] = 1'h1;
						strobeOut_nxt[k] = panelDataOut[k+3]; // RULE13
						strobeOe_nxt[k] = 1'h1;
					end
					sppm_pkg::OWN_GPIO: begin
						senseOut_nxt[k] = gpioDOut[k-1]; // RULE13
						senseOe_nxt[k] = gpioDOe[k-1];
						strobeOut_nxt[k] = gpioDOut[k+3]; // RULE13
						strobeOe_nxt[k] = gpioDOe[k+3];
					end
					default: begin
						sensePull_nxt[k] = 1'h1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			keySensePadOut_r <= {sppm_pkg::KEY_LINES{sppm_pkg::RST_OUT}};
			keySensePadOe_r <= {sppm_pkg::KEY_LINES{sppm_pkg::RST_OE}};
			keySensePullUp_r <= {sppm_pkg::KEY_LINES{sppm_pkg::RST_KEY_PULLUP}};
			keyStrobePadOut_r <= {sppm_pkg::KEY_LINES{sppm_pkg::RST_OUT}};
			keyStrobePadOe_r <= {sppm_pkg::KEY_LINES{sppm_pkg::RST_OE}};
		end else begin
			keySensePadOut_r <= senseOut_nxt; // RULE16
			keySensePadOe_r <= senseOe_nxt; // RULE16
			keySensePullUp_r <= sensePull_nxt;
			keyStrobePadOut_r <= strobeOut_nxt; // RULE16
			keyStrobePadOe_r <= strobeOe_nxt; // RULE16
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			keySenseIn_r <= '0;
			i2cSclIn_r <= 1'h0;
			i2cSdaIn_r <= 1'h0;
			gpioDIn_r <= '0;
		end else begin
			keySenseIn_r <= senseFilt; // RULE11
			i2cSclIn_r <= senseFilt[0]; // RULE11
			i2cSdaIn_r <= strobeFilt[0]; // RULE12
			gpioDIn_r <= {strobeFilt[4:1], senseFilt[4:1]}; // RULE16
		end
	end

	spi_float_a: assert property (@(posedge clock) disable iff (!rstn) // RULE15
		floatSpi |=> spiPadOe_r == '0)
		else $error("flash pins driven while floating code selected");
	cs1_pullup_a: assert property (@(posedge clock) disable iff (!rstn) // RULE3
		!resetActive_r ##1 !resetActive_r |-> !flashSelectOnePullUp_r)
		else $error("select pull-up left on after reset");
	pwm0_pulldown_a: assert property (@(posedge clock) disable iff (!rstn) // RULE7
		pwm0PullDown_r == resetActive_r)
		else $error("pull-down not tied to reset period");
	strap_hold_a: assert property (@(posedge clock) disable iff (!rstn) // RULE6
		!resetActive_r && !$fell(resetActive_r) |-> $stable(initDisplayEn_r))
		else $error("initial display strap changed after capture");
	mosi_single_a: assert property (@(posedge clock) disable iff (!rstn) // RULE4
		spiMasterEn && !dualLineMode && !floatSpi |=>
		spiPadOe_r[sppm_pkg::PAD_MOSI] && !spiPadOe_r[sppm_pkg::PAD_MISO]
		&& spiPadOut_r[sppm_pkg::PAD_MOSI] == $past(spiFn.mosi))
		else $error("single mode data pin directions wrong");
	gpio_c_pass_a: assert property (@(posedge clock) disable iff (!rstn) // RULE2
		!spiMasterEn && !floatSpi |=> spiPadOe_r == $past(gpioCOe[sppm_pkg::SPI_PADS-1:0]))
		else $error("port C enables not passed with master disabled");
	pwm1_select_a: assert property (@(posedge clock) disable iff (!rstn) // RULE9
		!clockTest && pwm1Sel == sppm_pkg::PWM1_ERR |=>
		pwm1PadOe_r && pwm1PadOut_r == $past(scanBandwidthErr | memRangeErr))
		else $error("second PWM pin error flag not routed");
	pwm1_input_a: assert property (@(posedge clock) disable iff (!rstn) // RULE10
		clockTest |=> !pwm1PadOe_r)
		else $error("second PWM pin driven in clock test mode");
	strobe_od_a: assert property (@(posedge clock) disable iff (!rstn) // RULE12
		lineOwner[1] == sppm_pkg::OWN_KEY |=> !keyStrobePadOut_r[1]
		&& keyStrobePadOe_r[1] == !$past(keyStrobeOut[1]))
		else $error("strobe line not open-drain");
	panel_clk_a: assert property (@(posedge clock) disable iff (!rstn) // RULE14
		!clockTest |=> panelScanClkOut_r == $past(scanPllClkTap))
		else $error("panel clock not taken from scan PLL");

endmodule

/* include/sppm_pkg.sv */
// Shared constants and carrier types for the flash/PWM/keypad pin multiplexer.
// Assumes pad cells outside resolve each pin from out/oe and apply pull controls.
package sppm_pkg;

	// Input synchroniser depth; agreement of the last two stages accepts a change
	localparam int SYNC_STAGES = 3;

	// Flash/SPI pad positions; the index also equals the general-purpose port C bit
	localparam int SPI_PADS = 5;
	localparam int PAD_SCLK = 0;
	localparam int PAD_MOSI = 1;
	localparam int PAD_MISO = 2;
	localparam int PAD_CS0 = 3;
	localparam int PAD_CS1 = 4;

	// Port C width and the bit that the first PWM pin lends
	localparam int GPIOC_W = 8;
	localparam int GPIOC_PWM0 = 7;

	// Keypad line count and port D width shared with lines one to four
	localparam int KEY_LINES = 5;
	localparam int GPIOD_W = 8;

	// Positions inside the synchronised pin vector
	localparam int IN_SPI = 0;
	localparam int IN_PWM0 = 5;
	localparam int IN_PWM1 = 6;
	localparam int IN_SENSE = 7;
	localparam int IN_STROBE = 12;
	localparam int IN_CLKTEST = 17;
	localparam int IN_CHIPTEST = 18;
	localparam int IN_W = 20;

	// Chip test-mode select codes
	localparam logic [1:0] TEST_NORMAL = 2'h0;
	localparam logic [1:0] TEST_FLOAT_SPI = 2'h1;

	// Reset values of pad controls
	localparam logic RST_OE = 1'h0;
	localparam logic RST_OUT = 1'h0;
	localparam logic RST_PWM0_PULLDOWN = 1'h1;
	localparam logic RST_KEY_PULLUP = 1'h1;
	localparam logic RST_INIT_DISPLAY = 1'h0;

	typedef enum logic [1:0] {PWM1_PWM, PWM1_OSC, PWM1_ERR} sppm_pwm1_sel_t;

	typedef enum logic [1:0] {OWN_KEY, OWN_PANEL, OWN_GPIO} sppm_owner_t;

	// Outputs of the serial-flash master toward the pins
	typedef struct packed {
		logic sclk;
		logic cs0n;
		logic cs1n;
		logic mosi;
		logic [1:0] dualOut;
		logic [1:0] dualOe;
	} sppm_spi_fn_t;

endpackage

/* bench/sppm_far_side.sv */
// Far-side pad model: flash, strap board, key matrix and panel clock pins.
// Pin order: spi[4:0], pwm0, pwm1, sense[4:0], strobe[4:0].
`timescale 1ns/100ps
module sppm_far_side (
	input wire logic clock,
	input wire logic [16:0] padOut,
	input wire logic [16:0] padOe,
	input wire logic [16:0] pullUp,
	input wire logic [16:0] pullDown,
	input wire logic [16:0] extOe,
	input wire logic [16:0] extVal,
	output logic [16:0] padIn
);
	logic flip_r = 1'b0;
	// Floating lines toggle so that a stale level never reads as valid
	always @(posedge clock) begin
		flip_r <= !flip_r;
	end
	always_comb begin
		for (int i = 0; i < 17; i++) begin
			// Two drivers on one pin show as unknown
			if (padOe[i] && extOe[i])
				padIn[i] = 1'bx;
			else if (padOe[i])
				padIn[i] = padOut[i];
			else if (extOe[i])
				padIn[i] = extVal[i];
			else if (pullUp[i] || pullDown[i])
				padIn[i] = pullUp[i];
			else
				padIn[i] = flip_r;
		end
	end
endmodule

/* bench/tb_top.sv */
// Bench top: drives the pin multiplexer controls and checks pad results.
// Assumes the far-side model resolves every pin each cycle.
`timescale 1ns/100ps
module tb_top;
	logic clock = 1'b0;
	logic rstn, flashSelectOnePullUp_r, pwm0PadIn, pwm0PadOut_r, pwm0PadOe_r, pwm0PullDown_r;
	logic pwm1PadIn, pwm1PadOut_r, pwm1PadOe_r, panelScanClkOut_r, clockTestPin, spiMasterEn;
	logic dualLineMode, spiMasterInData_r, pwmEn, pwm0Value, pwm0CoreClkSel, coreClkTap;
	logic pwm1Value, oscClkTap, scanBandwidthErr, memRangeErr, initDisplayEn_r, clockTestMode_r;
	logic extPanelScanClk_r, i2cMasterEn, i2cSclOut, i2cSdaOut, i2cSclIn_r, i2cSdaIn_r;
	logic scanPllClkTap;
	logic [4:0] spiPadIn, spiPadOut_r, spiPadOe_r, keySensePadIn, keySensePadOut_r;
	logic [4:0] keySensePadOe_r, keySensePullUp_r, keyStrobePadIn, keyStrobePadOut_r;
	logic [4:0] keyStrobePadOe_r, keyStrobeOut, keySenseIn_r;
	logic [1:0] chipTestPin, dualDataIn_r;
	logic [7:0] gpioCOut, gpioCOe, gpioCIn_r, panelDataOut, gpioDOut, gpioDOe, gpioDIn_r;
	logic [16:0] padIn, extOe, extVal;
	sppm_pkg::sppm_spi_fn_t spiFn;
	sppm_pkg::sppm_pwm1_sel_t pwm1Sel;
	sppm_pkg::sppm_owner_t [4:1] lineOwner;
	int errors, samplesChecked, cycles;
	always #25 clock = !clock;
	assign {keyStrobePadIn, keySensePadIn, pwm1PadIn, pwm0PadIn, spiPadIn} = padIn;
	sppm_pin_mux u_sppm_pin_mux (.*);
	// Board pull-ups sit on the open-drain strobes
	sppm_far_side u_sppm_far_side (.clock, .extOe, .extVal, .padIn,
		.padOut({keyStrobePadOut_r, keySensePadOut_r, pwm1PadOut_r, pwm0PadOut_r, spiPadOut_r}),
		.padOe({keyStrobePadOe_r, keySensePadOe_r, pwm1PadOe_r, pwm0PadOe_r, spiPadOe_r}),
		.pullUp({5'h1f, keySensePullUp_r, 2'h0, flashSelectOnePullUp_r, 4'h0}),
		.pullDown({11'h000, pwm0PullDown_r, 5'h00}));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Inputs always change a fixed 5 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask
	task automatic give_verdict();
		if (errors == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		{rstn, clockTestPin, spiMasterEn, dualLineMode, pwmEn, pwm0Value, pwm0CoreClkSel} = '0;
		{coreClkTap, pwm1Value, oscClkTap, scanBandwidthErr, memRangeErr, scanPllClkTap} = '0;
		{i2cMasterEn, i2cSclOut, i2cSdaOut, chipTestPin, gpioCOut, gpioCOe} = '0;
		{panelDataOut, gpioDOut, gpioDOe, extOe, extVal} = '0;
		spiFn = '0;
		keyStrobeOut = 5'h1f;
		pwm1Sel = sppm_pkg::PWM1_PWM;
		lineOwner = '{default: sppm_pkg::OWN_KEY};
		step(5);
		chk("selOnePull", 8'h01, flashSelectOnePullUp_r);
		chk("pwm0Pull", 8'h01, pwm0PullDown_r);
		chk("sensePull", 8'h1f, keySensePullUp_r);
		rstn = 1'b1;
		step(2);
		chk("initDisp", 8'h00, initDisplayEn_r);
		chk("pwm0Pull", 8'h00, pwm0PullDown_r);
		chk("selOnePull", 8'h00, flashSelectOnePullUp_r);
		chk("spiOe", 8'h00, spiPadOe_r);
		chk("pwm0Oe", 8'h00, pwm0PadOe_r);
		chk("pwm1Oe", 8'h01, pwm1PadOe_r);
		{gpioCOe, gpioCOut} = 16'h9b8a;
		{extOe[2], extVal[2]} = 2'h3;
		step(1);
		chk("spiOe", 8'h1b, spiPadOe_r);
		chk("spiOut", 8'h0a, spiPadOut_r);
		chk("pwm0", 8'h03, {pwm0PadOe_r, pwm0PadOut_r});
		step(8);
		chk("portC", 8'h8e, gpioCIn_r);
		gpioCOe = 8'h00;
		spiMasterEn = 1'b1;
		spiFn = '{sclk: 1'b1, cs0n: 1'b0, cs1n: 1'b1, mosi: 1'b1, default: '0};
		extVal[2] = 1'b0;
		step(1);
		chk("spiOe", 8'h1b, spiPadOe_r);
		chk("spiOut", 8'h13, spiPadOut_r);
		step(8);
		chk("misoIn", 8'h00, spiMasterInData_r);
		chk("portC", 8'h13, gpioCIn_r & 8'h1f);
		dualLineMode = 1'b1;
		{spiFn.dualOe, spiFn.dualOut} = 4'h5;
		extVal[2] = 1'b1;
		step(8);
		chk("spiOe", 8'h1b, spiPadOe_r);
		chk("dualIn", 8'h03, dualDataIn_r);
		{spiFn.dualOe, spiFn.dualOut} = 4'ha;
		step(1);
		extOe[2:1] = 2'h1;
		extVal[1] = 1'b0;
		step(8);
		chk("spiOe", 8'h1d, spiPadOe_r);
		chk("dualIn", 8'h02, dualDataIn_r);
		chipTestPin = 2'h1;
		step(8);
		chk("spiOe", 8'h00, spiPadOe_r);
		// Board strap holds the first PWM pin high through reset
		{extOe, extVal} = {17'h0_0020, 17'h0_0020};
		{spiMasterEn, dualLineMode, rstn} = 3'h0;
		step(5);
		chk("selOnePull", 8'h00, flashSelectOnePullUp_r);
		chipTestPin = 2'h0;
		rstn = 1'b1;
		step(2);
		chk("initDisp", 8'h01, initDisplayEn_r);
		chk("pwm0Pull", 8'h00, pwm0PullDown_r);
		extOe = '0;
		step(8);
		chk("initDisp", 8'h01, initDisplayEn_r);
		{pwmEn, pwm0Value, pwm0CoreClkSel, coreClkTap} = 4'hb;
		step(1);
		chk("pwm0", 8'h02, {pwm0PadOe_r, pwm0PadOut_r});
		pwmEn = 1'b0;
		step(1);
		chk("pwm0", 8'h03, {pwm0PadOe_r, pwm0PadOut_r});
		{pwm0CoreClkSel, gpioCOe, gpioCOut} = {1'b0, 8'h80, 8'h00};
		step(1);
		chk("pwm0", 8'h02, {pwm0PadOe_r, pwm0PadOut_r});
		for (int p = 0; p < 2; p++) begin
			{pwm1Value, memRangeErr} = {2{p[0]}};
			{oscClkTap, scanBandwidthErr} = {2{!p[0]}};
			for (int s = 0; s < 3; s++) begin
				pwm1Sel = sppm_pkg::sppm_pwm1_sel_t'(s);
				step(1);
				chk("pwm1", 8'(2 + (s == 0 ? p : s == 1 ? 1 - p : 1)), {pwm1PadOe_r, pwm1PadOut_r});
			end
		end
		clockTestPin = 1'b1;
		step(8);
		chk("pwm1Oe", 8'h00, pwm1PadOe_r);
		chk("clkTest", 8'h01, clockTestMode_r);
		for (int v = 1; v >= 0; v--) begin
			{extOe[6], extVal[6]} = {1'b1, v[0]};
			step(8);
			chk("extClk", 8'(3 * v), {extPanelScanClk_r, panelScanClkOut_r});
		end
		{extOe[6], clockTestPin} = 2'h0;
		step(8);
		for (int v = 1; v >= 0; v--) begin
			scanPllClkTap = v[0];
			step(2);
			chk("panelClk", 8'(v), panelScanClkOut_r);
		end
		keyStrobeOut = 5'h15;
		extOe[11:7] = 5'h05;
		step(8);
		chk("strobe", 8'h0a, keyStrobePadOe_r | keyStrobePadOut_r);
		chk("senseOe", 8'h00, keySensePadOe_r);
		chk("senseIn", 8'h1a, keySenseIn_r);
		chk("portD", 8'had, gpioDIn_r);
		extOe[7] = 1'b0;
		{i2cMasterEn, i2cSclOut, i2cSdaOut} = 3'h4;
		step(8);
		chk("strobeOe", 8'h0b, keyStrobePadOe_r);
		chk("senseOe", 8'h01, keySensePadOe_r);
		chk("i2cIn", 8'h00, {i2cSclIn_r, i2cSdaIn_r});
		{i2cSclOut, i2cSdaOut} = 2'h3;
		step(8);
		chk("i2cIn", 8'h03, {i2cSclIn_r, i2cSdaIn_r});
		{i2cMasterEn, keyStrobeOut, extOe} = {1'b0, 5'h1f, 17'h0_0000};
		lineOwner[1] = sppm_pkg::OWN_PANEL;
		lineOwner[2] = sppm_pkg::OWN_GPIO;
		{panelDataOut, gpioDOe, gpioDOut} = 24'h11_2202;
		step(2);
		chk("senseOe", 8'h06, keySensePadOe_r);
		chk("senseOut", 8'h06, keySensePadOut_r & keySensePadOe_r);
		chk("strobeOe", 8'h06, keyStrobePadOe_r);
		chk("strobeOut", 8'h02, keyStrobePadOut_r & keyStrobePadOe_r);
		chk("sensePull", 8'h19, keySensePullUp_r);
		give_verdict();
	end
endmodule
